/* File: hdl/pam_regs.svh */
// Register offsets, field positions and reset values of the management register bank
`ifndef PAM_REGS_SVH
`define PAM_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define PAM_ADDR_ID_HIGH     5'h02
`define PAM_ADDR_ID_LOW      5'h03
`define PAM_ADDR_ADV         5'h04
`define PAM_ADDR_PARTNER     5'h05
`define PAM_ADDR_EXP         5'h06
`define PAM_ADDR_RSVD_LO     5'h08
`define PAM_ADDR_RSVD_HI     5'h0F
`define PAM_ADDR_VSC         5'h10

// ****************************************************************
// Field positions
// ****************************************************************
`define PAM_ADV_NP           15
`define PAM_ADV_RSVD         14
`define PAM_ADV_RF           13
`define PAM_ADV_TECH_HI      12
`define PAM_ADV_TECH_LO      5
`define PAM_ADV_SEL_HI       4
`define PAM_ADV_SEL_LO       0
`define PAM_EXP_RSVD_HI      15
`define PAM_EXP_RSVD_LO      5
`define PAM_EXP_PDF          4
`define PAM_EXP_LPNP         3
`define PAM_EXP_NP           2
`define PAM_EXP_PR           1
`define PAM_EXP_LPAN         0
`define PAM_VSC_FLOW         15
`define PAM_VSC_SPARE        14
`define PAM_VSC_CSD          13
`define PAM_VSC_TXFC         12
`define PAM_VSC_SYNC         11
`define PAM_VSC_PD100        10
`define PAM_VSC_PD10         9
`define PAM_VSC_POL          8
`define PAM_VSC_T4           2
`define PAM_VSC_SPEED        1
`define PAM_VSC_DUPLEX       0
`define PAM_VSC_RSVD_HI      7
`define PAM_VSC_RSVD_LO      3

// ****************************************************************
// Fixed and reset values
// ****************************************************************
`define PAM_SEL_IEEE         5'h01
`define PAM_WORD_ZERO        16'h0000
`define PAM_BIT_RESET        1'b0
`define PAM_TECH_RESET       8'h00

`endif

/* File: hdl/pam_pkg.sv */
// Types shared by the management register bank
package pam_pkg;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } pam_req_t;

    typedef struct packed {
        logic [15:0] partnerWord;
        logic        partnerAck;
        logic        pageEvent;
        logic        faultEvent;
        logic        partnerNpAble;
        logic        partnerAnAble;
        logic        rxInSync;
        logic        pd100;
        logic        pd10;
        logic        polarityRev;
        logic        resT4;
        logic        resSpeed100;
        logic        resFullDuplex;
    } pam_status_t;

    typedef struct packed {
        logic        advRemoteFault;
        logic [7:0]  advTechAbility;
        logic        flowControlEn;
        logic        csDisconnectEn;
        logic        txFlowControlEn;
    } pam_ctrl_t;

endpackage

/* File: hdl/pam_mgmt_regs.sv */
// Management register bank: identifiers, negotiation registers and vendor status/control
`timescale 1ns/1ps
`default_nettype none
`include "pam_regs.svh"

// Notes on behaviour
// - Addresses 2 and 3 return fixed identifiers
// - Advertisement bit 15 reads zero, read-only
// - Advertisement bit 14 reserved, reads zero
// - Advertisement bit 13 writable remote fault
// - Advertisement bits 12:5 writable technology ability
// - Advertisement selector fixed at 00001
// - Partner register mirrors received partner page
// - Partner bit 14 shows acknowledge received
// - Expansion 15:5 and vendor 7:3 read zero
// - Parallel detection fault latches, clears on read
// - Expansion bit 3 shows partner next-page able
// - Expansion bit 2 reads zero, no next page
// - Page received latches, clears on read
// - Expansion bit 0 shows partner negotiation able
// - Addresses 8 to 15 hold no function
// - Vendor bit 15 enables flow control scheme
// - Vendor bit 13 enables carrier sense disconnect
// - Vendor bit 12 enables transmit flow control
// - Vendor bit 11 shows de-serializer in sync
// - Vendor bits 10, 9 show power-down
// - Vendor bit 8 shows reversed polarity
// - Vendor bits 2:0 show negotiated result
module pam_mgmt_regs #(
    parameter logic [15:0] ID_HIGH    = 16'h1234,  // Arbitrary value
    parameter logic [15:0] ID_LOW     = 16'h5678,  // Arbitrary value
    parameter logic [7:0]  TECH_RESET = `PAM_TECH_RESET
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 stationMode,
    input  wire pam_pkg::pam_req_t    req,
    input  wire pam_pkg::pam_status_t stat,
    output logic [15:0]               rdata,
    output logic                      rvalid,
    output pam_pkg::pam_ctrl_t        ctrl
);
    import pam_pkg::*;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    function automatic logic isMapped(input logic [4:0] a);
        case (a)
            `PAM_ADDR_ID_HIGH,
            `PAM_ADDR_ID_LOW,
            `PAM_ADDR_ADV,
            `PAM_ADDR_PARTNER,
            `PAM_ADDR_EXP,
            `PAM_ADDR_VSC:     isMapped = 1'b1;
            default:           isMapped = 1'b0;
        endcase
    endfunction

    function automatic logic isReserved(input logic [4:0] a);
        isReserved = (a >= `PAM_ADDR_RSVD_LO) && (a <= `PAM_ADDR_RSVD_HI);
    endfunction

    logic        wrAdv;
    logic        wrVsc;
    logic        rdExp;
    logic        advRf;
    logic [7:0]  advTech;
    logic        flowEn;
    logic        vscSpare;
    logic        csdEn;
    logic        txfcEn;
    logic        strapDone;
    logic        pdFault;
    logic        pageRcvd;
    pam_status_t statReg;
    logic [15:0] advWord;
    logic [15:0] expWord;
    logic [15:0] vscWord;
    logic [15:0] next_rdata;

    // Writes reach only the two writable registers; all else is dropped
    assign wrAdv = req.wr && (req.addr == `PAM_ADDR_ADV);
    assign wrVsc = req.wr && (req.addr == `PAM_ADDR_VSC);
    assign rdExp = req.rd && (req.addr == `PAM_ADDR_EXP);

    // ****************************************************************
    // Advertisement register
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            advRf   <= `PAM_BIT_RESET;
            advTech <= `PAM_TECH_RESET;
        end else if (!strapDone) begin
            advTech <= TECH_RESET;
        end else if (wrAdv) begin
            advRf   <= req.wdata[`PAM_ADV_RF];
            advTech <= req.wdata[`PAM_ADV_TECH_HI:`PAM_ADV_TECH_LO];
        end
    end

    // ****************************************************************
    // Vendor status and control register
    // ****************************************************************
    // Strap is caught one edge after reset release, never under reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strapDone <= 1'b0;
        end else begin
            strapDone <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flowEn   <= `PAM_BIT_RESET;
            vscSpare <= `PAM_BIT_RESET;
            csdEn    <= `PAM_BIT_RESET;
            txfcEn   <= `PAM_BIT_RESET;
        end else if (!strapDone) begin
            csdEn    <= stationMode;
        end else if (wrVsc) begin
            flowEn   <= req.wdata[`PAM_VSC_FLOW];
            vscSpare <= req.wdata[`PAM_VSC_SPARE];
            csdEn    <= req.wdata[`PAM_VSC_CSD];
            txfcEn   <= req.wdata[`PAM_VSC_TXFC];
        end
    end

    // ****************************************************************
    // Status capture and latched events
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            statReg <= '0;
        end else begin
            statReg <= stat;
        end
    end

    // Event in the clearing cycle wins, so no page or fault is lost
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pdFault  <= `PAM_BIT_RESET;
            pageRcvd <= `PAM_BIT_RESET;
        end else begin
            pdFault  <= stat.faultEvent | (pdFault & ~rdExp);
            pageRcvd <= stat.pageEvent | (pageRcvd & ~rdExp);
        end
    end

    // ****************************************************************
    // Read words
    // ****************************************************************
    always_comb begin
        advWord = `PAM_WORD_ZERO;
        advWord[`PAM_ADV_NP] = 1'b0;
        advWord[`PAM_ADV_RSVD] = 1'b0;
        advWord[`PAM_ADV_RF] = advRf;
        advWord[`PAM_ADV_TECH_HI:`PAM_ADV_TECH_LO] = advTech;
        advWord[`PAM_ADV_SEL_HI:`PAM_ADV_SEL_LO] = `PAM_SEL_IEEE;
    end

    always_comb begin
        expWord = `PAM_WORD_ZERO;
        expWord[`PAM_EXP_PDF] = pdFault;
        expWord[`PAM_EXP_LPNP] = statReg.partnerNpAble;
        expWord[`PAM_EXP_NP] = 1'b0;
        expWord[`PAM_EXP_PR] = pageRcvd;
        expWord[`PAM_EXP_LPAN] = statReg.partnerAnAble;
    end

    always_comb begin
        vscWord = `PAM_WORD_ZERO;
        vscWord[`PAM_VSC_FLOW] = flowEn;
        vscWord[`PAM_VSC_SPARE] = vscSpare;
        vscWord[`PAM_VSC_CSD] = csdEn;
        vscWord[`PAM_VSC_TXFC] = txfcEn;
        vscWord[`PAM_VSC_SYNC] = statReg.rxInSync;
        vscWord[`PAM_VSC_PD100] = statReg.pd100;
        vscWord[`PAM_VSC_PD10] = statReg.pd10;
        vscWord[`PAM_VSC_POL] = statReg.polarityRev;
        vscWord[`PAM_VSC_T4] = statReg.resT4;
        vscWord[`PAM_VSC_SPEED] = statReg.resSpeed100;
        vscWord[`PAM_VSC_DUPLEX] = statReg.resFullDuplex;
    end

    // ****************************************************************
    // Read multiplexer
    // ****************************************************************
    always_comb begin
        next_rdata = `PAM_WORD_ZERO;
        case (req.addr)
            `PAM_ADDR_ID_HIGH: begin
                next_rdata = ID_HIGH;
            end
            `PAM_ADDR_ID_LOW: begin
                next_rdata = ID_LOW;
            end
            `PAM_ADDR_ADV: begin
                next_rdata = advWord;
            end
            `PAM_ADDR_PARTNER: begin
                next_rdata = statReg.partnerWord;
                next_rdata[`PAM_ADV_RSVD] = statReg.partnerAck;
            end
            `PAM_ADDR_EXP: begin
                next_rdata = expWord;
            end
            `PAM_ADDR_VSC: begin
                next_rdata = vscWord;
            end
            default: begin
                next_rdata = `PAM_WORD_ZERO;
            end
        endcase
    end

    // Read data is registered so the word is stable for the serial shifter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata  <= `PAM_WORD_ZERO;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
            if (req.rd) begin
                rdata <= next_rdata;
            end
        end
    end

    assign ctrl.advRemoteFault  = advRf;
    assign ctrl.advTechAbility  = advTech;
    assign ctrl.flowControlEn   = flowEn;
    assign ctrl.csDisconnectEn  = csdEn;
    assign ctrl.txFlowControlEn = txfcEn;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_id_high;
        @(posedge clk) disable iff (!rst_n)
        req.rd && (req.addr == `PAM_ADDR_ID_HIGH) |=> rvalid && (rdata == ID_HIGH);
    endproperty
    a_id_high: assert property (p_id_high) else $error("identifier high wrong");

    property p_id_low;
        @(posedge clk) disable iff (!rst_n)
        req.rd && (req.addr == `PAM_ADDR_ID_LOW) |=> rvalid && (rdata == ID_LOW);
    endproperty
    a_id_low: assert property (p_id_low) else $error("identifier low changed");

    property p_adv_fixed;
        @(posedge clk) disable iff (!rst_n)
        req.rd && (req.addr == `PAM_ADDR_ADV)
            |=> (rdata[15:14] == 2'b00) && (rdata[4:0] == `PAM_SEL_IEEE);
    endproperty
    a_adv_fixed: assert property (p_adv_fixed) else $error("fixed adv bits wrong");

    property p_adv_write;
        @(posedge clk) disable iff (!rst_n)
        wrAdv && strapDone |=> (ctrl.advRemoteFault == $past(req.wdata[13]))
            && (ctrl.advTechAbility == $past(req.wdata[12:5]));
    endproperty
    a_adv_write: assert property (p_adv_write) else $error("adv write lost");

    property p_partner;
        @(posedge clk) disable iff (!rst_n)
        req.rd && (req.addr == `PAM_ADDR_PARTNER)
            |=> (rdata[13:0] == $past(statReg.partnerWord[13:0]))
            && (rdata[14] == $past(statReg.partnerAck));
    endproperty
    a_partner: assert property (p_partner) else $error("partner word wrong");

    property p_fault_hold;
        @(posedge clk) disable iff (!rst_n)
        stat.faultEvent ##1 !rdExp [*2] |=> pdFault;
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault not held");

    property p_fault_clear;
        @(posedge clk) disable iff (!rst_n)
        rdExp && pdFault ##0 !stat.faultEvent |=> (rdata[4] == 1'b1) && !pdFault;
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared");

    property p_page_setwins;
        @(posedge clk) disable iff (!rst_n)
        rdExp && stat.pageEvent |=> pageRcvd;
    endproperty
    a_page_setwins: assert property (p_page_setwins) else $error("page event lost");

    property p_page_clear;
        @(posedge clk) disable iff (!rst_n)
        rdExp && pageRcvd ##0 !stat.pageEvent |=> rdata[`PAM_EXP_PR] && !pageRcvd;
    endproperty
    a_page_clear: assert property (p_page_clear) else $error("page not cleared");

    property p_exp_zero;
        @(posedge clk) disable iff (!rst_n)
        req.rd && (req.addr == `PAM_ADDR_EXP) |=> (rdata[15:5] == 11'h000) && !rdata[2];
    endproperty
    a_exp_zero: assert property (p_exp_zero) else $error("expansion reserved set");

    property p_exp_status;
        @(posedge clk) disable iff (!rst_n)
        req.rd && (req.addr == `PAM_ADDR_EXP)
            |=> (rdata[`PAM_EXP_LPNP] == $past(statReg.partnerNpAble))
            && (rdata[`PAM_EXP_LPAN] == $past(statReg.partnerAnAble));
    endproperty
    a_exp_status: assert property (p_exp_status) else $error("partner bits wrong");

    property p_vsc_write;
        @(posedge clk) disable iff (!rst_n)
        wrVsc && strapDone |=> (flowEn == $past(req.wdata[15])) && (csdEn == $past(req.wdata[13]))
            && (txfcEn == $past(req.wdata[12]));
    endproperty
    a_vsc_write: assert property (p_vsc_write) else $error("vendor write lost");

    property p_vsc_status;
        @(posedge clk) disable iff (!rst_n)
        req.rd && (req.addr == `PAM_ADDR_VSC)
            |=> (rdata[7:3] == 5'h00) && (rdata[2:0] == $past({statReg.resT4,
                statReg.resSpeed100, statReg.resFullDuplex}));
    endproperty
    a_vsc_status: assert property (p_vsc_status) else $error("vendor status wrong");

    property p_vsc_levels;
        @(posedge clk) disable iff (!rst_n)
        req.rd && (req.addr == `PAM_ADDR_VSC)
            |=> (rdata[`PAM_VSC_SYNC:`PAM_VSC_POL] == $past({statReg.rxInSync,
                statReg.pd100, statReg.pd10, statReg.polarityRev}));
    endproperty
    a_vsc_levels: assert property (p_vsc_levels) else $error("vendor levels wrong");

    property p_unmapped;
        @(posedge clk) disable iff (!rst_n)
        req.rd && !isMapped(req.addr) |=> rvalid && (rdata == `PAM_WORD_ZERO);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_strap;
        @(posedge clk) disable iff (!rst_n)
        !strapDone |=> csdEn == $past(stationMode);
    endproperty
    a_strap: assert property (p_strap) else $error("disconnect default wrong");

    c_fault_read: cover property (@(posedge clk) disable iff (!rst_n) rdExp && pdFault);
    c_vsc_write: cover property (@(posedge clk) disable iff (!rst_n) wrVsc ##2 req.rd);
    c_rsvd_read: cover property (@(posedge clk) disable iff (!rst_n)
        req.rd && isReserved(req.addr));
    c_set_clear: cover property (@(posedge clk) disable iff (!rst_n)
        rdExp && stat.pageEvent);

endmodule
`default_nettype wire

/* File: sim/pam_station_mgr.sv */
// Station manager model issuing register reads and writes on the strobe port
`timescale 1ns/1ps
`default_nettype none
module pam_station_mgr (
    input  wire logic            clk,
    input  wire logic [15:0]     rdata,
    input  wire logic            rvalid,
    output var pam_pkg::pam_req_t req
);
    import pam_pkg::*;

    initial req = '0;

    // Strobe is raised after an edge so back-to-back calls never collide in one step
    task automatic rd_reg(input logic [4:0] a, output logic [15:0] d, output logic ok);
        int n;
        ok = 1'b0;
        d = 16'h0000;
        @(posedge clk);
        #1;
        req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
        @(posedge clk);
        #1;
        req = '{rd: 1'b0, wr: 1'b0, addr: a, wdata: 16'h0000};
        for (n = 0; n < 4 && !ok; n++) begin
            if (rvalid === 1'b1) begin
                ok = 1'b1;
                d = rdata;
            end else begin
                @(posedge clk);
                #1;
            end
        end
    endtask

    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        #1;
        req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clk);
        #1;
        req = '{rd: 1'b0, wr: 1'b0, addr: a, wdata: d};
    endtask
endmodule
`default_nettype wire

/* File: sim/phy_autoneg_mgmt_registers_tb.sv */
// Self-checking bench for the management register bank
`timescale 1ns/1ps
`default_nettype none
module phy_autoneg_mgmt_registers_tb;
    import pam_pkg::*;

    localparam logic [15:0] IDH  = 16'hA5C3;  // Arbitrary value
    localparam logic [15:0] IDL  = 16'h3C5A;  // Arbitrary value
    localparam logic [7:0]  TECH = 8'hA5;

    logic        clk         = 1'b0;
    logic        rst_n       = 1'b0;
    logic        stationMode = 1'b1;
    pam_req_t    req;
    pam_status_t stat        = '0;
    logic [15:0] rdata;
    logic        rvalid;
    pam_ctrl_t   ctrl;
    int          miscompares = 0;
    int          comparisons = 0;
    logic [31:0] rnd         = 32'hF981A6A7;
    logic        advRf;
    logic [7:0]  tech;
    logic [3:0]  vscHi;
    logic        pdf;
    logic        pr;

    always #5 clk = ~clk;

    pam_mgmt_regs #(.ID_HIGH(IDH), .ID_LOW(IDL), .TECH_RESET(TECH)) uut (
        .clk(clk), .rst_n(rst_n), .stationMode(stationMode), .req(req), .stat(stat),
        .rdata(rdata), .rvalid(rvalid), .ctrl(ctrl));

    pam_station_mgr mgr (.clk(clk), .rdata(rdata), .rvalid(rvalid), .req(req));

    // ****************************************************************
    // Reference model
    // ****************************************************************
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction

    function automatic logic [15:0] expect_word(input logic [4:0] a);
        case (a)
            5'h02: return IDH;
            5'h03: return IDL;
            5'h04: return {2'h0, advRf, tech, 5'h01};
            5'h05: return {stat.partnerWord[15], stat.partnerAck, stat.partnerWord[13:0]};
            5'h06: return {11'h000, pdf, stat.partnerNpAble, 1'b0, pr, stat.partnerAnAble};
            5'h10: return {vscHi, stat.rxInSync, stat.pd100, stat.pd10, stat.polarityRev,
                           5'h00, stat.resT4, stat.resSpeed100, stat.resFullDuplex};
            default: return 16'h0000;
        endcase
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic read_cmp(input logic [4:0] a);
        logic [15:0] d;
        logic        ok;
        logic [15:0] e;
        e = expect_word(a);
        mgr.rd_reg(a, d, ok);
        check({15'h0000, ok}, 16'h0001);
        check(d, e);
        // Latched expansion bits are gone once they have been read
        if (a == 5'h06) begin
            pdf = 1'b0;
            pr = 1'b0;
        end
    endtask

    task automatic write_upd(input logic [4:0] a, input logic [15:0] d);
        mgr.wr_reg(a, d);
        if (a == 5'h04) begin
            advRf = d[13];
            tech = d[12:5];
        end
        if (a == 5'h10) vscHi = d[15:12];
        check({4'h0, ctrl}, {4'h0, advRf, tech, vscHi[3], vscHi[1], vscHi[0]});
    endtask

    task automatic do_reset(input logic m);
        rst_n = 1'b0;
        stationMode = m;
        advRf = 1'b0;
        tech = TECH;
        vscHi = {2'h0, m, 1'b0};
        pdf = 1'b0;
        pr = 1'b0;
        repeat (16) @(posedge clk);
        check({rvalid, 3'h0, ctrl}, 16'h0000);
        check(rdata, 16'h0000);
        #1;
        rst_n = 1'b1;
        @(posedge clk);
    endtask

    // Events are one-cycle pulses; the model latches them as the bank should
    task automatic pulse(input logic pg, input logic flt);
        stat = pam_status_t'(stat | {17'h00000, pg, flt, 9'h000});
        pr = pr | pg;
        pdf = pdf | flt;
        @(posedge clk);
        #1;
        stat = pam_status_t'(stat & 28'hFFFF9FF);
    endtask

    task automatic finish_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        #200000;
        miscompares++;
        finish_test();
    end

    initial begin
        int i;
        int k;
        do_reset(1'b1);
        for (i = 0; i < 32; i++) begin
            read_cmp(i[4:0]);
        end
        for (i = 0; i < 64; i++) begin
            rnd = lfsr_next(rnd);
            write_upd((i < 32) ? i[4:0] : rnd[20:16], rnd[15:0]);
            if (i[2:0] == 3'h7) read_cmp(rnd[20:16]);
        end
        for (i = 0; i < 32; i++) begin
            read_cmp(i[4:0]);
        end
        for (i = 0; i < 24; i++) begin
            rnd = lfsr_next(rnd);
            stat = pam_status_t'(rnd[27:0] & 28'hFFFF9FF);
            @(posedge clk);
            #1;
            read_cmp(5'h05);
            read_cmp(5'h06);
            read_cmp(5'h10);
        end
        for (k = 1; k < 4; k++) begin
            pulse(k[1], k[0]);
            read_cmp(5'h06);
            read_cmp(5'h06);
        end
        // Events held across a read: the set must win over the clear
        stat = pam_status_t'(stat | 28'h0000600);
        pr = 1'b1;
        pdf = 1'b1;
        read_cmp(5'h06);
        stat = pam_status_t'(stat & 28'hFFFF9FF);
        pr = 1'b1;
        pdf = 1'b1;
        read_cmp(5'h06);
        read_cmp(5'h06);
        pulse(1'b1, 1'b1);
        write_upd(5'h06, 16'hFFFF);
        read_cmp(5'h06);
        pulse(1'b1, 1'b1);
        do_reset(1'b0);
        read_cmp(5'h06);
        read_cmp(5'h10);
        read_cmp(5'h04);
        finish_test();
    end
endmodule
`default_nettype wire
